// file: common/adc_seq_pkg.sv
// Purpose: shared constants for the four-input sequencing converter control
// Assumes: pclk at 125 MHz, serial clock well below pclk / 8
// Notes:   control word is 12 bits, sent msb first on the serial input
package adc_seq_pkg;

  // control word layout (12-bit frame word, stored image is bits 10..0)
  localparam int CW_W       = 12;          // bits shifted in per frame
  localparam int CTRL_W     = 11;          // bits held in the control image
  localparam int BIT_WRITE  = 11;          // load gate
  localparam int BIT_SEQ_HI = 10;          // sequence_mode_hi
  localparam int BIT_CH_HI  = 7;           // channel_select_hi
  localparam int BIT_CH_LO  = 6;           // channel_select_lo
  localparam int BIT_PM_HI  = 5;           // power_ctl_hi
  localparam int BIT_PM_LO  = 4;           // power_ctl_lo
  localparam int BIT_SEQ_LO = 3;           // sequence_mode_lo
  localparam int BIT_RANGE  = 1;           // 1: one times reference
  localparam int BIT_CODING = 0;           // 1: straight binary

  // power control codes
  localparam logic [1:0] PM_NORMAL = 2'h3;
  localparam logic [1:0] PM_FULL   = 2'h2;
  localparam logic [1:0] PM_AUTO   = 2'h1;
  localparam logic [1:0] PM_BAD    = 2'h0;

  // control image after reset: normal power, channel 0, no sequence
  localparam logic [10:0] CTRL_RST = 11'h030;

  // serial frame timing, counted in serial clock falling edges
  localparam int CONV_TIME_NS     = 800;   // conversion time at reference rate
  localparam int REF_SCLK_KHZ     = 20000; // reference serial clock rate
  localparam int CONV_SCLK_CYCLES = CONV_TIME_NS * REF_SCLK_KHZ / 1000000;
  localparam int FRAME_EDGES      = CONV_SCLK_CYCLES;
  localparam int CW_EDGES         = 12;    // edges carrying the control word
  localparam int DATA_FIRST_EDGE  = 4;     // edge putting result msb out
  localparam int COMMIT_EDGE      = 14;    // control load, mux switch, track

  // wake-up from shutdown, in pclk cycles (least time, rounded up)
  localparam int PCLK_MHZ    = 125;
  localparam int WAKE_TIME_NS = 1000;
  localparam int WAKE_CYCLES  = (WAKE_TIME_NS * PCLK_MHZ + 999) / 1000;

  // apb register map (byte addresses)
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_RESULT = 12'h008;
  localparam logic [11:0] OFS_CONFIG = 12'h00C;
  localparam logic [0:0]  CFG_RST    = 1'h1;   // serial port enabled

  // frame state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_XFER  = 3'b010,
    ST_QUIET = 3'b100
  } frame_st_t;

endpackage

// file: rtl/adc_seq_ctrl.sv
// Purpose: control logic of a four-input 12-bit sar converter with sequencer
// Assumes: serial pins asynchronous to pclk; comparator level on pclk
// Notes:   serial clock edges found by oversampling; apb for monitoring and serial port enable
//
// Functional notes
// - sequence bit hi 0: channel from prior write
// - mode 1,0 write keeps running sequence
// - mode 1,1 converts channel 0 up to final
// - each chip-select fall moves to next channel
// - serial clock shifts, loads and steps sar
// - conversion length fixed in serial clock cycles
// - range bit selects one or two times reference
// - coding bit: straight binary or twos complement
// - two power bits select power behaviour
// - four inputs, sequencer cycles preselected set
// - write bit gates load of 11 bits
// - channel bits loaded at conversion end
// - after final channel sequence wraps to 0
// - power codes; wake time before valid conversion
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_ctrl
  import adc_seq_pkg::*;
#(
  parameter int WAKE_CNT = WAKE_CYCLES     // wake-up wait in pclk cycles
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  // analog front end
  input  wire logic        cmp_above,     // input at or above dac level
  output logic      [1:0]  chan_sel,      // input mux select
  output logic             track,         // 1 track, 0 hold
  output logic      [11:0] dac_code,      // sar trial code
  output logic             range_2x,      // full scale two times reference
  output logic             power_down     // analog circuitry off
);

  // synchronised pins and edges
  logic        cs_n_s, sclk_s, din_s;     // synchronised levels
  logic        cs_n_d, sclk_d;            // previous samples
  logic        cs_fall, cs_rise, sclk_fall;

  pin_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({cs_n, sclk, din}),
    .q     ({cs_n_s, sclk_s, din_s})
  );

  // edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b1;
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  logic        port_en_r;                 // config: serial port enable
  assign cs_fall   = cs_n_d & ~cs_n_s & port_en_r;
  assign cs_rise   = ~cs_n_d & cs_n_s;
  assign sclk_fall = sclk_d & ~sclk_s & ~cs_n_s;

  // frame state and edge counter
  frame_st_t   st_r, st_nxt;
  logic [4:0]  edge_r, edge_nxt;          // falling edges seen this frame
  logic        in_frame;                  // edge counts toward the frame

  assign in_frame = (st_r == ST_XFER) & sclk_fall;
  assign edge_nxt = in_frame ? 5'(edge_r + 5'h01) : edge_r;

  // frame sequencing
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE:  if (cs_fall) st_nxt = ST_XFER;
      ST_XFER: begin
        if (cs_rise) st_nxt = ST_IDLE;            // frame cut short
        else if (in_frame && edge_nxt == 5'(FRAME_EDGES)) st_nxt = ST_QUIET;
      end
      ST_QUIET: if (cs_rise) st_nxt = ST_IDLE;    // cs may idle low
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= ST_IDLE;
      edge_r <= 5'h00;
    end else begin
      st_r   <= st_nxt;
      edge_r <= cs_fall ? 5'h00 : edge_nxt;
    end
  end

  // frame milestones
  logic commit, cw_done, frame_end;
  assign cw_done   = in_frame & (edge_nxt == 5'(CW_EDGES));
  assign commit    = in_frame & (edge_nxt == 5'(COMMIT_EDGE));
  assign frame_end = in_frame & (edge_nxt == 5'(FRAME_EDGES));

  // control word shift-in on serial clock falling edges
  logic [CW_W-1:0] shift_r;               // bits collected so far
  logic [CW_W-1:0] cw_r;                  // full word, held to commit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= 12'h000;
      cw_r    <= 12'h000;
    end else if (in_frame && edge_nxt <= 5'(CW_EDGES)) begin
      shift_r <= {shift_r[CW_W-2:0], din_s};
      if (cw_done) cw_r <= {shift_r[CW_W-2:0], din_s};
    end
  end

  // control image and sequencer state
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [1:0]  next_chan_r, next_chan_nxt; // channel for next conversion
  logic [1:0]  cur_chan_r;                 // channel of running conversion
  logic [1:0]  seq_last_r, seq_last_nxt;   // final channel of sequence
  logic        seq_on_r, seq_on_nxt;       // sequence running
  logic        coding_cur_r;               // coding for this result

  // decoded fields of the incoming word
  wire        cw_write  = cw_r[BIT_WRITE];
  wire        cw_seq_hi = cw_r[BIT_SEQ_HI];
  wire        cw_seq_lo = cw_r[BIT_SEQ_LO];
  wire [1:0]  cw_chan   = cw_r[BIT_CH_HI:BIT_CH_LO];
  wire [1:0]  cw_pm     = cw_r[BIT_PM_HI:BIT_PM_LO];
  wire [1:0]  seq_adv   = (cur_chan_r == seq_last_r) ? 2'h0 : 2'(cur_chan_r + 2'h1);
  wire [1:0]  pm_cur    = ctrl_r[BIT_PM_HI:BIT_PM_LO];
  wire [1:0]  pm_new    = ctrl_nxt[BIT_PM_HI:BIT_PM_LO];

  // load, sequence start, continue and exit
  always_comb begin
    ctrl_nxt      = ctrl_r;
    next_chan_nxt = next_chan_r;
    seq_last_nxt  = seq_last_r;
    seq_on_nxt    = seq_on_r;
    if (commit) begin
      if (cw_write) begin
        ctrl_nxt = cw_r[CTRL_W-1:0];
        // invalid power code leaves power bits as they were
        if (cw_pm == PM_BAD) ctrl_nxt[BIT_PM_HI:BIT_PM_LO] = pm_cur;
      end
      if (cw_write && cw_seq_hi && cw_seq_lo) begin
        seq_on_nxt    = 1'b1;
        seq_last_nxt  = cw_chan;
        next_chan_nxt = 2'h0;
      end else if (cw_write && cw_seq_hi) begin
        next_chan_nxt = seq_on_r ? seq_adv : cw_chan;
      end else if (cw_write) begin
        seq_on_nxt    = 1'b0;
        next_chan_nxt = cw_chan;
      end else if (seq_on_r) begin
        next_chan_nxt = seq_adv;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r       <= CTRL_RST;
      next_chan_r  <= 2'h0;
      seq_last_r   <= 2'h0;
      seq_on_r     <= 1'b0;
      cur_chan_r   <= 2'h0;
      coding_cur_r <= 1'b0;
    end else begin
      ctrl_r      <= ctrl_nxt;
      next_chan_r <= next_chan_nxt;
      seq_last_r  <= seq_last_nxt;
      seq_on_r    <= seq_on_nxt;
      if (cs_fall) begin
        cur_chan_r   <= next_chan_r;
        coding_cur_r <= ctrl_r[BIT_CODING];
      end
    end
  end

  // mux follows the selected channel from the commit edge on
  assign chan_sel = next_chan_r;
  assign range_2x = ~ctrl_r[BIT_RANGE];

  // successive approximation, one bit per serial clock falling edge
  logic [11:0] sar_r;                      // trial and decided bits
  logic [3:0]  bit_r;                      // bit under trial
  logic        sar_busy_r;                 // trials remain
  logic        track_r;
  logic [11:0] trial_mask;

  assign trial_mask = 12'h001 << bit_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_r      <= 12'h000;
      bit_r      <= 4'h0;
      sar_busy_r <= 1'b0;
      track_r    <= 1'b1;
    end else if (cs_fall) begin
      sar_r      <= 12'h800;               // first trial at half scale
      bit_r      <= 4'hB;
      sar_busy_r <= 1'b1;
      track_r    <= 1'b0;                  // sample taken on cs fall
    end else begin
      if (in_frame && sar_busy_r) begin
        // keep the trial bit only when input reached the dac level
        sar_r <= (cmp_above ? sar_r : (sar_r & ~trial_mask))
                 | ((bit_r != 4'h0) ? (trial_mask >> 1) : 12'h000);
        bit_r      <= (bit_r != 4'h0) ? 4'(bit_r - 4'h1) : 4'h0;
        sar_busy_r <= (bit_r != 4'h0);
      end
      if (commit || cs_rise) track_r <= 1'b1;
    end
  end

  assign dac_code = sar_r;
  assign track    = track_r;

  // serial output word: two zeros, channel, result
  logic [15:0] out_word;
  logic [3:0]  out_idx;
  logic        dout_r, dout_oe_r;
  logic [15:0] result_r;                   // last complete word

  assign out_word = {2'b00, cur_chan_r, sar_r[11] ^ ~coding_cur_r, sar_r[10:0]};
  assign out_idx  = 4'(5'h0F - edge_nxt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_r    <= 1'b0;
      dout_oe_r <= 1'b0;
      result_r  <= 16'h0000;
    end else begin
      dout_oe_r <= ~cs_n_s & (st_nxt != ST_IDLE);
      if (cs_fall) dout_r <= 1'b0;
      else if (in_frame) dout_r <= (edge_nxt < 5'(FRAME_EDGES)) ? out_word[out_idx] : 1'b0;
      if (frame_end) result_r <= out_word;
    end
  end

  assign dout    = dout_r;
  assign dout_oe = dout_oe_r;

  // power management and wake-up timing
  logic        pd_r;
  logic [7:0]  wake_r;                     // cycles left before valid use
  logic        pd_nxt;

  assign pd_nxt = commit ? (pm_new == PM_FULL || pm_new == PM_AUTO)
                : (cs_fall && pm_cur == PM_AUTO) ? 1'b0 : pd_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_r   <= 1'b0;
      wake_r <= 8'h00;
    end else begin
      pd_r <= pd_nxt;
      if (pd_r && !pd_nxt) wake_r <= 8'(WAKE_CNT);
      else if (wake_r != 8'h00) wake_r <= 8'(wake_r - 8'h01);
    end
  end

  assign power_down = pd_r;
  wire awake = ~pd_r & (wake_r == 8'h00);

  // apb decode
  wire hit_ctrl   = (paddr == OFS_CTRL);
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_result = (paddr == OFS_RESULT);
  wire hit_config = (paddr == OFS_CONFIG);
  wire hit_any    = hit_ctrl | hit_status | hit_result | hit_config;
  wire setup_rd   = psel & ~penable & ~pwrite;
  wire access_wr  = psel & penable & pwrite & hit_config & pstrb[0];

  wire [31:0] status_word = {19'h00000, (st_r != ST_IDLE), awake, pd_r,
                             seq_on_r, seq_last_r, next_chan_r, cur_chan_r, 3'h0};
  wire [31:0] rd_mux = hit_ctrl   ? {21'h000000, ctrl_r}
                     : hit_status ? status_word
                     : hit_result ? {16'h0000, result_r}
                     : hit_config ? {31'h00000000, port_en_r}
                     : 32'h00000000;

  // read data captured in setup, config written in access
  logic [31:0] prdata_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h00000000;
      port_en_r <= CFG_RST;
    end else begin
      if (setup_rd) prdata_r <= rd_mux;
      if (access_wr) port_en_r <= pwdata[0];
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start_seq;
    commit && cw_write && cw_seq_hi && cw_seq_lo;
  endsequence
  sequence s_seq_first;
    ##1 seq_on_r && next_chan_r == 2'h0;
  endsequence
  sequence s_frame_open;
    cs_fall ##1 (st_r == ST_XFER && edge_r == 5'h00);
  endsequence

  a_seq_start_zero: assert property (s_start_seq |-> s_seq_first)
    else $error("sequence start did not reset channel counter");
  a_seq_keep_run: assert property (commit && cw_write && cw_seq_hi && !cw_seq_lo && seq_on_r
    |=> seq_on_r)
    else $error("mode 1,0 write stopped the sequence");
  a_single_chan: assert property (commit && cw_write && !cw_seq_hi
    |=> !seq_on_r && next_chan_r == $past(cw_chan))
    else $error("single mode channel not taken from write");
  a_seq_wrap: assert property (commit && !cw_write && seq_on_r && cur_chan_r == seq_last_r
    |=> next_chan_r == 2'h0)
    else $error("sequence did not wrap to channel 0");
  a_no_write: assert property (commit && !cw_write |=> $stable(ctrl_r))
    else $error("control image changed without write bit");
  a_cs_advance: assert property (s_frame_open |-> cur_chan_r == $past(next_chan_r))
    else $error("chip-select fall did not take next channel");
  a_commit_edge: assert property (commit |=> edge_r == 5'(COMMIT_EDGE) && track)
    else $error("track not resumed at the commit edge");
  a_frame_len: assert property (frame_end |=> st_r == ST_QUIET && edge_r == 5'(FRAME_EDGES))
    else $error("frame did not end after 16 edges");
  a_range_sel: assert property (commit && cw_write
    |=> range_2x == !$past(cw_r[BIT_RANGE]))
    else $error("range output disagrees with written range bit");
  a_pm_normal: assert property (commit && pm_new == PM_NORMAL |=> !power_down)
    else $error("normal power code left converter down");
  a_wake_wait: assert property ($fell(pd_r) |-> !awake [*8])
    else $error("ready flagged before wake time");
  a_msb_coding: assert property (in_frame && edge_nxt == 5'(DATA_FIRST_EDGE)
    |=> dout == ($past(sar_r[11]) ^ ~coding_cur_r))
    else $error("result msb coding wrong");

endmodule
`default_nettype wire

// file: rtl/pin_sync.sv
// Purpose: two-stage synchroniser for pins from outside the pclk domain
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // pins in, synchronised levels out
  input  wire logic [W-1:0]  d,
  output logic      [W-1:0]  q
);

  logic [W-1:0] meta_r;                    // first stage, read by q only

  // two flops per bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire

// file: test/adc_seq_ctrl_tb.sv
// Purpose: self-checking bench for the sequencing converter control
// Assumes: wake count shortened to 8 pclk cycles
// Notes:   comparator modelled from a fixed input level per channel
`timescale 1ns/1ps
`default_nettype none
module adc_seq_ctrl_tb;
  import adc_seq_pkg::*;
  logic        pclk, presetn;          // clock and reset
  logic [11:0] paddr;                  // apb request
  logic        psel, penable, pwrite;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr;
  logic        cs_n, sclk, din, dout, dout_oe; // serial pins
  logic        cmp_above, track, range_2x, power_down;
  logic [1:0]  chan_sel;
  logic [11:0] dac_code;
  logic [31:0] d;                      // read data scratch
  logic        e;                      // error flag scratch
  logic        port_on;                // serial port enable expected
  logic [15:0] r16;                    // raw frame word scratch
  int          fails, n_compared, cycles;
  logic [11:0] vin [4] = '{12'h123, 12'h7FF, 12'hA5C, 12'hFFF}; // input levels

  adc_seq_ctrl #(.WAKE_CNT(8)) adc_seq_ctrl_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe), .cmp_above(cmp_above), .chan_sel(chan_sel),
    .track(track), .dac_code(dac_code), .range_2x(range_2x), .power_down(power_down));

  serial_host serial_host_i (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));

  // clock
  always #4 pclk = ~pclk;

  // comparator: input level against trial code
  always @(posedge pclk) cmp_above <= (vin[chan_sel] >= dac_code);

  // hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  // driver enable follows the frame while the port is on
  always @(negedge sclk) chk({31'h0, dout_oe}, {31'h0, port_on});

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, waits for pready; only the hang guard ends a wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one frame, result word checked against channel and coding in force
  task automatic frame(input logic [11:0] w, input logic [1:0] ch, input logic cod);
    logic [15:0] r;
    serial_host_i.xfer(w, r);
    chk({16'h0, r}, {16'h0, 2'b00, ch, cod ? vin[ch] : vin[ch] ^ 12'h800});
    repeat (4) @(posedge pclk);
    chk({19'h0, track, dac_code}, {19'h0, 1'b1, vin[ch]});
  endtask

  task automatic close_out();
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF; cmp_above = 1'b0;
    fails = 0; n_compared = 0; cycles = 0;
    port_on = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    // reset state and register map
    apb(1'b0, OFS_CTRL, 32'h0); chk(d, {21'h0, CTRL_RST});
    apb(1'b1, OFS_CONFIG, 32'h1);
    apb(1'b0, OFS_CONFIG, 32'h0); chk(d, 32'h1);
    apb(1'b0, 12'h010, 32'h0); chk({31'h0, e}, 32'h1);
    chk(d, 32'h00000000);
    chk({27'h0, range_2x, track, power_down, chan_sel}, 32'h18);
    // per-write channel selection
    frame(12'h8B3, 2'd0, 1'b0);
    chk({30'h0, chan_sel}, 32'h2);
    chk({31'h0, range_2x}, 32'h0);
    apb(1'b0, OFS_CTRL, 32'h0); chk(d, 32'h0B3);
    frame(12'h000, 2'd2, 1'b1);
    apb(1'b0, OFS_CTRL, 32'h0); chk(d, 32'h0B3);
    apb(1'b0, OFS_RESULT, 32'h0); chk(d, {20'h0, 4'h2, vin[2]});
    // continuous sequence, final channel 2, with wrap
    frame(12'hCBB, 2'd2, 1'b1);
    chk({30'h0, chan_sel}, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0); chk(d, 32'h00000B10);
    for (int i = 0; i < 5; i++) frame(12'h000, 2'(i % 3), 1'b1);
    // write that keeps the sequence running
    frame(12'hC31, 2'd2, 1'b1);
    chk({31'h0, range_2x}, 32'h1);
    frame(12'h000, 2'd0, 1'b1);
    // leave the sequence
    frame(12'h8F0, 2'd1, 1'b1);
    frame(12'h000, 2'd3, 1'b0);
    frame(12'h000, 2'd3, 1'b0);
    // serial port off: frame ignored, nothing loaded
    apb(1'b1, OFS_CONFIG, 32'h0);
    port_on = 1'b0;
    serial_host_i.xfer(12'h8B3, r16);
    chk({16'h0, r16}, 32'h0);
    chk({30'h0, chan_sel}, 32'h3);
    apb(1'b1, OFS_CONFIG, 32'h1);
    port_on = 1'b1;
    // power codes: full, invalid, auto, normal
    frame(12'h8E0, 2'd3, 1'b0);
    chk({31'h0, power_down}, 32'h1);
    frame(12'h8C0, 2'd3, 1'b0);
    chk({31'h0, power_down}, 32'h1);
    apb(1'b0, OFS_CTRL, 32'h0); chk(d, 32'h0E0);
    frame(12'h8D0, 2'd3, 1'b0);
    chk({31'h0, power_down}, 32'h1);
    frame(12'h8F0, 2'd3, 1'b0);
    chk({31'h0, power_down}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire

// file: test/serial_host.sv
// Purpose: serial host model driving chip select, serial clock and din
// Assumes: link clock period 125 ns, no phase relation to pclk
// Notes:   clock stands high between frames; din shows inverse when idle
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  // serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  localparam realtime HALF = 62.5;    // half link period
  localparam realtime GAP  = 1100.0;  // idle before frame, covers wake-up

  // idle pin levels
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  // one frame: control word out msb first, 16 result bits back
  task automatic xfer(input logic [11:0] w, output logic [15:0] r);
    #(GAP);                           // wake-up allowance
    cs_n = 1'b0;
    din  = w[11];                     // load gate goes first
    #(HALF);
    r[15] = dout;
    for (int n = 1; n <= 16; n++) begin
      sclk = 1'b0;
      #(HALF);
      if (n < 16) r[15-n] = dout;     // settled half a period after fall
      sclk = 1'b1;
      din  = (n < 12) ? w[11-n] : ~din; // changed on rising, taken on falling
      #(HALF);
    end
    cs_n = 1'b1;
    din  = ~din;                      // released line does not keep its value
  endtask
endmodule
`default_nettype wire
